// File: flm_pkg.sv
// shared constants for the flash lock and memory map block
package flm_pkg;
    // ------------------------------------------------------------
    // code address map (region ends, each region starts at the previous end or its own base)
    // ------------------------------------------------------------
    localparam logic [15:0] FLM_ROM_END = 16'ha000;
    localparam logic [15:0] FLM_FAC_END = 16'ha400;
    localparam logic [15:0] FLM_UC_BASE = 16'hb000;
    localparam logic [15:0] FLM_UC_END = 16'he000;
    localparam logic [15:0] FLM_EXT_END = 16'he800;
    localparam logic [15:0] FLM_CFG_END = 16'he900;
    localparam logic [15:0] FLM_RET_BASE = 16'hf000;
    localparam logic [15:0] FLM_RET_END = 16'hf0a0;
    localparam logic [2:0] FLM_RG_NONE = 3'h0;
    localparam logic [2:0] FLM_RG_ROM = 3'h1;
    localparam logic [2:0] FLM_RG_FAC = 3'h2;
    localparam logic [2:0] FLM_RG_UC = 3'h3;
    localparam logic [2:0] FLM_RG_EXT = 3'h4;
    localparam logic [2:0] FLM_RG_CFG = 3'h5;
    localparam logic [2:0] FLM_RG_RET = 3'h6;
    // ------------------------------------------------------------
    // flash check bits: four hamming bits plus overall parity
    // ------------------------------------------------------------
    localparam int FLM_ECC_W = 5;
    localparam logic [7:0] FLM_ECC_M1 = 8'h5b;
    localparam logic [7:0] FLM_ECC_M2 = 8'h6d;
    localparam logic [7:0] FLM_ECC_M4 = 8'h8e;
    localparam logic [7:0] FLM_ECC_M8 = 8'hf0;
    localparam logic [31:0] FLM_ECC_POS = 32'hcba97653;
    // ------------------------------------------------------------
    // lock bytes, sectors and commands
    // ------------------------------------------------------------
    localparam logic [7:0] FLM_LOCK_ON = 8'h69;
    localparam logic [3:0] FLM_LOCK_TOL = 4'h3;
    localparam logic [1:0] FLM_SEC_EXT = 2'h0;
    localparam logic [1:0] FLM_SEC_UC = 2'h1;
    localparam logic [1:0] FLM_SEC_CFG = 2'h2;
    localparam logic [2:0] FLM_OP_READ = 3'h0;
    localparam logic [2:0] FLM_OP_LINE_WR = 3'h1;
    localparam logic [2:0] FLM_OP_ERASE_SEC = 3'h2;
    localparam logic [2:0] FLM_OP_ERASE_ALL = 3'h3;
    localparam logic [2:0] FLM_OP_SET_CFG_LOCK = 3'h4;
    localparam logic [4:0] FLM_LINE_OFS = 5'h1f;
    // ------------------------------------------------------------
    // retention ram, data ram and sfr paging
    // ------------------------------------------------------------
    localparam int FLM_RET_BLOCKS = 5;
    localparam int FLM_RET_BLK_SH = 5;
    localparam logic [7:0] FLM_UPPER_BASE = 8'h80;
    localparam logic [7:0] FLM_PAGE_REG_ADDR = 8'h8e;
    localparam logic [1:0] FLM_PAGE_MAX = 2'h2;
    localparam logic [1:0] FLM_PWR_RUN = 2'h0;
    localparam logic [1:0] FLM_PWR_DOWN = 2'h1;
    localparam logic [1:0] FLM_PWR_DEEP = 2'h2;
    localparam logic [1:0] FLM_PWR_TXLP = 2'h3;
endpackage

// File: flm_memory_guard.sv
// code map decode, flash ecc, lock-byte protection and data ram/sfr decode
`timescale 1ns/10ps

// What this block does
// - decode 64 kB code space into rom, factory, user, extended, config, retention
// - generate five check bits for every programmed flash byte
// - on read correct single-bit errors and flag double-bit errors
// - rom and factory sector are read-blocked by the factory lock for unprivileged reads
// - a lock byte equal to 0x69 enables its sector lock
// - lock values within hamming distance three of 0x69 also count as enabled
// - lock chain extended, then user code, then user config
// - lock bytes are sampled once after reset only
// - debug entry refused while the user code lock is effective
// - program mode line write of one aligned 32-byte line
// - program mode sector erase deletes whole sectors
// - dedicated command sets the user config lock; none for user code
// - five 32-byte retention blocks, each kept powered by its enable bit
// - retention ram decoded in external data space
// - enabled retention blocks stay powered in every power state
// - upper addresses go to sfr when direct, to ram when indirect
// - lower data ram reachable by direct or indirect access
// - three sfr pages chosen by two page bits
// - page register decoded at one address in every page
// - upper data ram reserved for the transmit machine during transmission
// - data ram unpowered in power-down and deep idle, lower bank in tx low power
module flm_memory_guard
    import flm_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic code_rd_i,
    input wire logic [15:0] code_addr_i,
    input wire logic fw_priv_i,
    input wire logic flash_wr_i,
    input wire logic [7:0] flash_wdata_i,
    input wire logic flash_rd_i,
    input wire logic [7:0] flash_rdata_i,
    input wire logic [4:0] flash_recc_i,
    input wire logic factory_lock_i,
    input wire logic [7:0] ext_lock_byte_i,
    input wire logic [7:0] user_code_lock_byte_i,
    input wire logic [7:0] user_config_lock_byte_i,
    input wire logic prog_mode_i,
    input wire logic debug_req_i,
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_op_i,
    input wire logic [1:0] cmd_sector_i,
    input wire logic [15:0] cmd_addr_i,
    input wire logic [4:0] retention_block_power_enables_i,
    input wire logic [1:0] pwr_state_i,
    input wire logic tx_active_i,
    input wire logic xdata_req_i,
    input wire logic [15:0] xdata_addr_i,
    input wire logic data_req_i,
    input wire logic [7:0] data_addr_i,
    input wire logic data_direct_i,
    input wire logic data_wr_i,
    input wire logic [7:0] data_wdata_i,
    output logic [2:0] region_o,
    output logic code_rd_ok_o,
    output logic [4:0] ecc_wr_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_corrected_o,
    output logic rd_double_err_o,
    output logic factory_lock_o,
    output logic extended_code_lock_o,
    output logic user_code_lock_o,
    output logic user_config_lock_o,
    output logic debug_grant_o,
    output logic cmd_grant_o,
    output logic cmd_deny_o,
    output logic cfg_lock_wr_o,
    output logic [4:0] ret_pwr_o,
    output logic lo_ram_pwr_o,
    output logic hi_ram_pwr_o,
    output logic ret_sel_o,
    output logic [2:0] ret_block_o,
    output logic sfr_sel_o,
    output logic ram_sel_o,
    output logic ram_deny_o,
    output logic [1:0] sfr_page_o
);
    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // check bits of one byte, overall parity on top
    function automatic logic [4:0] ecc_of(input logic [7:0] d);
        logic [3:0] h;
        h[0] = ^(d & FLM_ECC_M1);
        h[1] = ^(d & FLM_ECC_M2);
        h[2] = ^(d & FLM_ECC_M4);
        h[3] = ^(d & FLM_ECC_M8);
        return {(^d) ^ (^h), h};
    endfunction
    // a lock counts as set within a small hamming distance of the key
    function automatic logic lock_on(input logic [7:0] b);
        return $countones(b ^ FLM_LOCK_ON) <= int'(FLM_LOCK_TOL);
    endfunction
    // ------------------------------------------------------------
    // code address decode
    // ------------------------------------------------------------
    logic [2:0] region_next;
    logic sec_lock;
    // gap addresses answer as no region
    always_comb begin
        if (code_addr_i < FLM_ROM_END) begin
            region_next = FLM_RG_ROM;
        end else if (code_addr_i < FLM_FAC_END) begin
            region_next = FLM_RG_FAC;
        end else if (code_addr_i >= FLM_UC_BASE && code_addr_i < FLM_UC_END) begin
            region_next = FLM_RG_UC;
        end else if (code_addr_i >= FLM_UC_END && code_addr_i < FLM_EXT_END) begin
            region_next = FLM_RG_EXT;
        end else if (code_addr_i >= FLM_EXT_END && code_addr_i < FLM_CFG_END) begin
            region_next = FLM_RG_CFG;
        end else if (code_addr_i >= FLM_RET_BASE && code_addr_i < FLM_RET_END) begin
            region_next = FLM_RG_RET;
        end else begin
            region_next = FLM_RG_NONE;
        end
    end
    // extended, user and config locks only hide code from the outside programmer; the factory lock from unprivileged reads
    always_comb begin
        unique case (region_next)
            FLM_RG_ROM, FLM_RG_FAC: sec_lock = factory_lock_o && !fw_priv_i;
            FLM_RG_EXT: sec_lock = prog_mode_i && extended_code_lock_o;
            FLM_RG_UC: sec_lock = prog_mode_i && user_code_lock_o;
            FLM_RG_CFG: sec_lock = prog_mode_i && user_config_lock_o;
            default: sec_lock = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            region_o <= FLM_RG_NONE;
            code_rd_ok_o <= 1'b0;
        end else begin
            region_o <= code_rd_i ? region_next : region_o;
            code_rd_ok_o <= code_rd_i && (region_next != FLM_RG_NONE) && !sec_lock;
        end
    end
    // ------------------------------------------------------------
    // flash ecc: generate on program, secded on read
    // ------------------------------------------------------------
    logic [4:0] rd_calc;
    logic [3:0] syn;
    logic par_err;
    logic [7:0] fix;
    always_comb begin
        rd_calc = ecc_of(flash_rdata_i);
        syn = rd_calc[3:0] ^ flash_recc_i[3:0];
        par_err = (^flash_rdata_i) ^ (^flash_recc_i) != 1'b0;
        fix = 8'h00;
        for (int i = 0; i < 8; i++) begin
            fix[i] = par_err && (syn == FLM_ECC_POS[i*4 +: 4]);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ecc_wr_o <= 5'h00;
        end else if (flash_wr_i) begin
            ecc_wr_o <= ecc_of(flash_wdata_i);
        end
    end
    // a syndrome pointing at a check bit needs no data flip
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
            rd_corrected_o <= 1'b0;
            rd_double_err_o <= 1'b0;
        end else begin
            rd_valid_o <= flash_rd_i;
            if (flash_rd_i) begin
                rd_data_o <= flash_rdata_i ^ fix;
                rd_corrected_o <= par_err && (fix != 8'h00 || $onehot0(syn));
                rd_double_err_o <= (!par_err && syn != 4'h0) || (par_err && fix == 8'h00 && syn > 4'h8);
            end
        end
    end
    // ------------------------------------------------------------
    // lock sampling after reset
    // ------------------------------------------------------------
    logic locks_taken_reg;
    logic ext_on, uc_on, cfg_on;
    assign ext_on = lock_on(ext_lock_byte_i);
    assign uc_on = lock_on(user_code_lock_byte_i);
    assign cfg_on = lock_on(user_config_lock_byte_i);
    // taken once after release so later writes wait for the next reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            locks_taken_reg <= 1'b0;
            factory_lock_o <= 1'b1;
            extended_code_lock_o <= 1'b1;
            user_code_lock_o <= 1'b1;
            user_config_lock_o <= 1'b1;
        end else if (!locks_taken_reg) begin
            locks_taken_reg <= 1'b1;
            factory_lock_o <= factory_lock_i;
            extended_code_lock_o <= ext_on;
            user_code_lock_o <= ext_on && uc_on;
            user_config_lock_o <= ext_on && uc_on && cfg_on;
        end
    end
    // ------------------------------------------------------------
    // debug entry and flash commands
    // ------------------------------------------------------------
    logic sel_lock, any_lock, line_ok, cmd_ok;
    assign any_lock = extended_code_lock_o;
    assign line_ok = (cmd_addr_i[4:0] & FLM_LINE_OFS) == 5'h00;
    always_comb begin
        unique case (cmd_sector_i)
            FLM_SEC_EXT: sel_lock = extended_code_lock_o;
            FLM_SEC_UC: sel_lock = user_code_lock_o;
            FLM_SEC_CFG: sel_lock = user_config_lock_o;
            default: sel_lock = 1'b1;
        endcase
    end
    // in program mode locked sectors can still be wiped, but only all together
    always_comb begin
        cmd_ok = 1'b0;
        if (prog_mode_i) begin
            unique case (cmd_op_i)
                FLM_OP_READ: cmd_ok = !sel_lock;
                FLM_OP_LINE_WR: cmd_ok = !sel_lock && line_ok;
                FLM_OP_ERASE_SEC: cmd_ok = !any_lock && cmd_sector_i != FLM_SEC_EXT;
                FLM_OP_ERASE_ALL: cmd_ok = 1'b1;
                FLM_OP_SET_CFG_LOCK: cmd_ok = !user_config_lock_o;
                default: cmd_ok = 1'b0;
            endcase
        end else begin
            unique case (cmd_op_i)
                FLM_OP_READ: cmd_ok = cmd_sector_i <= FLM_SEC_CFG;
                FLM_OP_LINE_WR: cmd_ok = cmd_sector_i != FLM_SEC_EXT && !sel_lock && line_ok;
                FLM_OP_ERASE_SEC: cmd_ok = cmd_sector_i == FLM_SEC_UC || cmd_sector_i == FLM_SEC_CFG;
                default: cmd_ok = 1'b0;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            debug_grant_o <= 1'b0;
            cmd_grant_o <= 1'b0;
            cmd_deny_o <= 1'b0;
            cfg_lock_wr_o <= 1'b0;
        end else begin
            debug_grant_o <= debug_req_i && locks_taken_reg && !user_code_lock_o;
            cmd_grant_o <= cmd_valid_i && cmd_ok;
            cmd_deny_o <= cmd_valid_i && !cmd_ok;
            cfg_lock_wr_o <= cmd_valid_i && cmd_ok && cmd_op_i == FLM_OP_SET_CFG_LOCK;
        end
    end
    // ------------------------------------------------------------
    // retention ram and data ram power
    // ------------------------------------------------------------
    logic [15:0] xoff;
    assign xoff = xdata_addr_i - FLM_RET_BASE;
    // disabled blocks only keep power while the core runs
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ret_pwr_o <= 5'h00;
            lo_ram_pwr_o <= 1'b0;
            hi_ram_pwr_o <= 1'b0;
        end else begin
            ret_pwr_o <= retention_block_power_enables_i | {FLM_RET_BLOCKS{pwr_state_i == FLM_PWR_RUN}};
            lo_ram_pwr_o <= pwr_state_i == FLM_PWR_RUN;
            hi_ram_pwr_o <= pwr_state_i == FLM_PWR_RUN || pwr_state_i == FLM_PWR_TXLP;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ret_sel_o <= 1'b0;
            ret_block_o <= 3'h0;
        end else begin
            ret_sel_o <= xdata_req_i && xdata_addr_i >= FLM_RET_BASE && xdata_addr_i < FLM_RET_END;
            ret_block_o <= xoff[FLM_RET_BLK_SH +: 3];
        end
    end
    // ------------------------------------------------------------
    // data ram versus sfr decode and page register
    // ------------------------------------------------------------
    logic upper;
    logic page_wr;
    assign upper = data_addr_i >= FLM_UPPER_BASE;
    assign page_wr = data_req_i && data_wr_i && data_direct_i && data_addr_i == FLM_PAGE_REG_ADDR;
    // page register decodes regardless of the current page
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sfr_page_o <= 2'h0;
        end else if (page_wr && data_wdata_i[1:0] <= FLM_PAGE_MAX) begin
            sfr_page_o <= data_wdata_i[1:0];
        end
    end
    // while tx_active_i is high the transmit machine owns upper ram, so indirect core access is turned away
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sfr_sel_o <= 1'b0;
            ram_sel_o <= 1'b0;
            ram_deny_o <= 1'b0;
        end else begin
            sfr_sel_o <= data_req_i && upper && data_direct_i;
            ram_sel_o <= data_req_i && (!upper || (!data_direct_i && !tx_active_i));
            ram_deny_o <= data_req_i && upper && !data_direct_i && tx_active_i;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_rom_read;
        code_rd_i && code_addr_i < FLM_ROM_END;
    endsequence
    property p_rom_region;
        s_rom_read |=> region_o == FLM_RG_ROM;
    endproperty
    a_rom_region: assert property (p_rom_region) else $error("rom address not decoded");
    property p_ecc_flag;
        flash_rd_i |=> rd_valid_o && !(rd_corrected_o && rd_double_err_o);
    endproperty
    a_ecc_flag: assert property (p_ecc_flag) else $error("ecc flags inconsistent");
    property p_ecc_clean;
        flash_rd_i && flash_recc_i == ecc_of(flash_rdata_i) |=>
            rd_data_o == $past(flash_rdata_i) && !rd_corrected_o && !rd_double_err_o;
    endproperty
    a_ecc_clean: assert property (p_ecc_clean) else $error("clean byte altered");
    property p_lock_hold;
        locks_taken_reg |=> $stable(user_code_lock_o) && $stable(extended_code_lock_o);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock changed without reset");
    property p_chain;
        (user_config_lock_o |-> user_code_lock_o) and (user_code_lock_o |-> extended_code_lock_o);
    endproperty
    a_chain: assert property (p_chain) else $error("lock chain broken");
    property p_debug;
        debug_req_i && user_code_lock_o |=> !debug_grant_o;
    endproperty
    a_debug: assert property (p_debug) else $error("debug granted while locked");
    sequence s_ext_change;
        cmd_valid_i && !prog_mode_i && cmd_sector_i == FLM_SEC_EXT &&
        (cmd_op_i == FLM_OP_LINE_WR || cmd_op_i == FLM_OP_ERASE_SEC);
    endsequence
    property p_ext_protect;
        s_ext_change |=> cmd_deny_o && !cmd_grant_o;
    endproperty
    a_ext_protect: assert property (p_ext_protect) else $error("extended sector changed");
    property p_page;
        page_wr && data_wdata_i[1:0] > FLM_PAGE_MAX |=> $stable(sfr_page_o);
    endproperty
    a_page: assert property (p_page) else $error("illegal page taken");
    property p_tx_upper;
        data_req_i && upper && !data_direct_i && tx_active_i |=> !ram_sel_o && ram_deny_o;
    endproperty
    a_tx_upper: assert property (p_tx_upper) else $error("upper ram given to core in tx");
    property p_ram_off;
        pwr_state_i == FLM_PWR_DOWN || pwr_state_i == FLM_PWR_DEEP |=> !lo_ram_pwr_o && !hi_ram_pwr_o;
    endproperty
    a_ram_off: assert property (p_ram_off) else $error("data ram powered when off");
    property p_ret_keep;
        pwr_state_i != FLM_PWR_RUN |=> ret_pwr_o == $past(retention_block_power_enables_i);
    endproperty
    a_ret_keep: assert property (p_ret_keep) else $error("retention power wrong");
endmodule

// File: flm_flash_cell_model.sv
// flash cell model that stores one byte with its check bits and plays them back
`timescale 1ns/10ps
module flm_flash_cell_model (
    input wire logic clk_i,
    input wire logic flash_wr_i,
    input wire logic [7:0] flash_wdata_i,
    input wire logic [4:0] ecc_wr_i,
    input wire logic flash_rd_i,
    input wire logic [12:0] flip_i,
    output logic [7:0] flash_rdata_o,
    output logic [4:0] flash_recc_o
);
    logic [7:0] cell_reg;
    logic [4:0] chk_reg;
    logic wr_d_reg;
    // check bits come one cycle after the byte, so they are captured late
    always_ff @(posedge clk_i) begin
        wr_d_reg <= flash_wr_i;
        if (flash_wr_i) begin
            cell_reg <= flash_wdata_i;
        end
        if (wr_d_reg) begin
            chk_reg <= ecc_wr_i;
        end
    end
    // off a read the lines show the inverse, so stale data can never pass
    assign flash_rdata_o = flash_rd_i ? cell_reg ^ flip_i[7:0] : ~cell_reg;
    assign flash_recc_o = flash_rd_i ? chk_reg ^ flip_i[12:8] : ~chk_reg;
endmodule

// File: tb.sv
// self-checking bench for the flash lock and memory map guard
`timescale 1ns/10ps
module tb
    import flm_pkg::*;
;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clk_i = 0, nrst_i = 0, code_rd_i = 0, fw_priv_i = 0, flash_wr_i = 0, flash_rd_i = 0, factory_lock_i = 1;
    logic prog_mode_i = 0, debug_req_i = 0, cmd_valid_i = 0, tx_active_i = 0, xdata_req_i = 0, data_req_i = 0;
    logic data_direct_i = 0, data_wr_i = 0;
    logic [7:0] flash_wdata_i = 0, ext_lock_byte_i = 0, user_code_lock_byte_i = 0, user_config_lock_byte_i = 0;
    logic [7:0] data_addr_i = 0, data_wdata_i = 0, flash_rdata_i, rd_data_o;
    logic [15:0] code_addr_i = 0, cmd_addr_i = 0, xdata_addr_i = 0;
    logic [4:0] retention_block_power_enables_i = 0, flash_recc_i, ecc_wr_o, ret_pwr_o, e;
    logic [2:0] cmd_op_i = 0, region_o, ret_block_o;
    logic [1:0] cmd_sector_i = 0, pwr_state_i = 0, sfr_page_o;
    logic code_rd_ok_o, rd_valid_o, rd_corrected_o, rd_double_err_o, factory_lock_o, extended_code_lock_o;
    logic user_code_lock_o, user_config_lock_o, debug_grant_o, cmd_grant_o, cmd_deny_o, cfg_lock_wr_o;
    logic lo_ram_pwr_o, hi_ram_pwr_o, ret_sel_o, sfr_sel_o, ram_sel_o, ram_deny_o;
    logic [12:0] flip = 0;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    // lock bytes written as 0x69 or 0x00, plus near-miss values
    localparam logic [27:0] LKT [6] = '{28'h0000008, 28'h690000c, 28'h696900e, 28'h696969f, 28'h0069698,
        28'h6e6e66e};
    localparam logic [19:0] CMAP [15] = '{20'h00002, 20'h9fff2, 20'ha0004, 20'ha3ff4, 20'ha4000, 20'hb0007,
        20'hdfff7, 20'he0009, 20'he7ff9, 20'he800b, 20'he8ffb, 20'he9000, 20'hf000d, 20'hf09fd, 20'hf0a00};
    localparam logic [14:0] RDT [4] = '{15'h0000, 15'h0012, 15'h0802, 15'h000d};
    localparam logic [6:0] PWT [4] = '{7'h7f, 7'h14, 7'h14, 7'h15};
    localparam logic [19:0] XT [3] = '{20'hf0209, 20'hf09fc, 20'hf0008};
    flm_memory_guard flm_memory_guard_i (.*);
    flm_flash_cell_model flm_flash_cell_model_i (.clk_i, .flash_wr_i, .flash_wdata_i, .ecc_wr_i(ecc_wr_o),
        .flash_rd_i, .flip_i(flip), .flash_rdata_o(flash_rdata_i), .flash_recc_o(flash_recc_i));
    // clock and a cycle ceiling well above the roughly 95 cycles needed
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [3:0] lk();
        return {factory_lock_o, extended_code_lock_o, user_code_lock_o, user_config_lock_o};
    endfunction
    // lock bytes only count at the edge after release, so they are set first
    task automatic boot(input logic [7:0] eb, ub, cb);
        nrst_i = 0;
        ext_lock_byte_i = eb;
        user_code_lock_byte_i = ub;
        user_config_lock_byte_i = cb;
        repeat (3) @(negedge clk_i);
        chk("reset_locks", 4'hf, lk());
        nrst_i = 1;
        @(negedge clk_i);
    endtask
    // strobes stay high between calls so commands run back to back
    task automatic cmd(input logic [2:0] op, input logic [1:0] sec, input logic [15:0] a, input logic [2:0] ex);
        cmd_valid_i = 1;
        cmd_op_i = op;
        cmd_sector_i = sec;
        cmd_addr_i = a;
        @(negedge clk_i);
        chk("cmd", ex, {cmd_grant_o, cmd_deny_o, cfg_lock_wr_o});
    endtask
    task automatic dreq(input logic [7:0] a, input logic dir, wr, input logic [7:0] wd, input logic [2:0] ex);
        data_req_i = 1;
        data_addr_i = a;
        data_direct_i = dir;
        data_wr_i = wr;
        data_wdata_i = wd;
        @(negedge clk_i);
        chk("data", ex, {sfr_sel_o, ram_sel_o, ram_deny_o});
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        foreach (LKT[i]) begin
            boot(LKT[i][27:20], LKT[i][19:12], LKT[i][11:4]);
            chk("locks", LKT[i][3:0], lk());
        end
        ext_lock_byte_i = 8'h00;
        user_code_lock_byte_i = 8'h00;
        debug_req_i = 1;
        repeat (2) @(negedge clk_i);
        chk("locks_held", 4'he, lk());
        chk("debug", 1'b0, debug_grant_o);
        boot(8'h69, 8'h00, 8'h00);
        @(negedge clk_i);
        chk("debug", 1'b1, debug_grant_o);
        debug_req_i = 0;
        $display("lock test done");
        code_rd_i = 1;
        foreach (CMAP[i]) begin
            code_addr_i = CMAP[i][19:4];
            @(negedge clk_i);
            chk("code", CMAP[i][3:0], {region_o, code_rd_ok_o});
        end
        fw_priv_i = 1;
        code_addr_i = 16'h0000;
        @(negedge clk_i);
        chk("code_fw", 4'h3, {region_o, code_rd_ok_o});
        fw_priv_i = 0;
        prog_mode_i = 1;
        code_addr_i = 16'he000;
        @(negedge clk_i);
        chk("code_prog", 4'h8, {region_o, code_rd_ok_o});
        code_rd_i = 0;
        $display("code map test done");
        cmd(FLM_OP_LINE_WR, FLM_SEC_UC, 16'hb000, 3'h4);
        cmd(FLM_OP_LINE_WR, FLM_SEC_UC, 16'hb001, 3'h2);
        cmd(FLM_OP_LINE_WR, FLM_SEC_CFG, 16'he8e0, 3'h4);
        cmd(FLM_OP_LINE_WR, FLM_SEC_EXT, 16'he000, 3'h2);
        cmd(FLM_OP_READ, FLM_SEC_EXT, 16'he000, 3'h2);
        cmd(FLM_OP_ERASE_SEC, FLM_SEC_UC, 16'hb000, 3'h2);
        cmd(FLM_OP_ERASE_ALL, FLM_SEC_UC, 16'hb000, 3'h4);
        cmd(FLM_OP_SET_CFG_LOCK, FLM_SEC_CFG, 16'he800, 3'h5);
        prog_mode_i = 0;
        cmd(FLM_OP_READ, FLM_SEC_EXT, 16'he000, 3'h4);
        cmd(FLM_OP_LINE_WR, FLM_SEC_EXT, 16'he000, 3'h2);
        cmd(FLM_OP_ERASE_SEC, FLM_SEC_EXT, 16'he000, 3'h2);
        cmd(FLM_OP_ERASE_SEC, FLM_SEC_UC, 16'hb000, 3'h4);
        cmd(FLM_OP_SET_CFG_LOCK, FLM_SEC_CFG, 16'he800, 3'h2);
        cmd_valid_i = 0;
        boot(8'h00, 8'h00, 8'h00);
        prog_mode_i = 1;
        cmd(FLM_OP_ERASE_SEC, FLM_SEC_UC, 16'hb000, 3'h4);
        cmd_valid_i = 0;
        boot(8'h69, 8'h69, 8'h69);
        cmd(FLM_OP_SET_CFG_LOCK, FLM_SEC_CFG, 16'he800, 3'h2);
        cmd(FLM_OP_LINE_WR, FLM_SEC_CFG, 16'he800, 3'h2);
        cmd_valid_i = 0;
        prog_mode_i = 0;
        $display("command test done");
        flash_wr_i = 1;
        flash_wdata_i = 8'ha5;
        @(negedge clk_i);
        flash_wr_i = 0;
        e[0] = ^(8'ha5 & FLM_ECC_M1);
        e[1] = ^(8'ha5 & FLM_ECC_M2);
        e[2] = ^(8'ha5 & FLM_ECC_M4);
        e[3] = ^(8'ha5 & FLM_ECC_M8);
        e[4] = ^{8'ha5, e[3:0]};
        chk("ecc", e, ecc_wr_o);
        @(negedge clk_i);
        flash_rd_i = 1;
        foreach (RDT[i]) begin
            flip = RDT[i][14:2];
            @(negedge clk_i);
            chk("rd_flags", {1'b1, RDT[i][1:0]}, {rd_valid_o, rd_corrected_o, rd_double_err_o});
            if (!RDT[i][0]) chk("rd_data", 8'ha5, rd_data_o);
        end
        flash_rd_i = 0;
        $display("ecc test done");
        dreq(8'h90, 1, 0, 8'h00, 3'h4);
        dreq(8'h90, 0, 0, 8'h00, 3'h2);
        dreq(8'h10, 1, 0, 8'h00, 3'h2);
        dreq(8'h10, 0, 0, 8'h00, 3'h2);
        tx_active_i = 1;
        dreq(8'h90, 0, 0, 8'h00, 3'h1);
        tx_active_i = 0;
        dreq(FLM_PAGE_REG_ADDR, 1, 1, 8'h02, 3'h4);
        dreq(FLM_PAGE_REG_ADDR, 1, 1, 8'h03, 3'h4);
        data_req_i = 0;
        @(negedge clk_i);
        chk("page", 2'h2, sfr_page_o);
        dreq(FLM_PAGE_REG_ADDR, 1, 1, 8'h01, 3'h4);
        data_req_i = 0;
        @(negedge clk_i);
        chk("page", 2'h1, sfr_page_o);
        $display("data test done");
        retention_block_power_enables_i = 5'h05;
        foreach (PWT[i]) begin
            pwr_state_i = i[1:0];
            @(negedge clk_i);
            chk("power", PWT[i], {ret_pwr_o, lo_ram_pwr_o, hi_ram_pwr_o});
        end
        xdata_req_i = 1;
        foreach (XT[i]) begin
            xdata_addr_i = XT[i][19:4];
            @(negedge clk_i);
            chk("xdata", XT[i][3:0], {ret_sel_o, ret_block_o});
        end
        xdata_req_i = 0;
        $display("retention test done");
        give_verdict();
    end
endmodule
